//--- spwm_top.sv
// Overview of operation
// R01: Bits 6..4 route group B to pins
// R02: Bits 2..0 route group A to pins
// R03: Divide code selects 128 down to 1
// R04: Group B invert bit flips B waveform
// R05: Group A invert bit flips A waveform
// R06: Sync bit lets comparator stop outputs
// R07: Mode bit 0 selects one-pulse operation
// R08: Enable with zero period halts, locks period
// R09: Software writes period before enabling
// R10: Sixteen-bit period in two byte registers
// R11: Sixteen-bit duty in two byte registers
// R12: Wide dead band trims pulse end
// R13: Short dead band delays pulse start
// R14: Enable bit gates the PWM interrupt
// R15: Request flag sticky, software clears by zero
// R16: Global enable masks all interrupts
// R17: Output high when counter starts at zero
// R18: Output low once counter reaches duty
// R19: Overflow sets flag, counter restarts
// R20: One pulse clears enable, pins revert
// R21: Interrupt only when flag and enables set
// R22: Pins switch to PWM at cycle boundary
`timescale 1ns/1ps
`default_nettype none
module spwm_top (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o,
	input wire logic cmp_trig_i,
	input wire logic [5:0] gpio_out_i,
	input wire logic [5:0] gpio_oe_i,
	output logic [5:0] pin_out_o,
	output logic [5:0] pin_oe_o,
	output logic irq_o
);

	// ********************************************************
	// Register file
	// ********************************************************
	logic [7:0] chan_sel_q;
	logic [6:0] mode_q;
	logic en_q;
	logic en_d;
	logic [15:0] period_q;
	logic [15:0] duty_q;
	logic [15:0] dbw_q;
	logic [7:0] dbs_q;
	logic pwm_irq_en_q;
	logic flag_q;
	logic flag_d;
	logic global_en_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	logic wr_global;
	logic wr_mode;
	logic wr_per_lo;
	logic wr_per_hi;
	logic wr_dbw_lo;
	logic wr_dbw_hi;
	logic wr_duty_lo;
	logic wr_duty_hi;
	logic wr_dbs;
	logic wr_chan;
	logic wr_irq;
	logic period_lock;

	assign wr_global = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_GLOBAL_IRQ);
	assign wr_mode = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_MODE);
	assign wr_per_lo = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_PERIOD_LO) && !period_lock;
	assign wr_per_hi = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_PERIOD_HI) && !period_lock;
	assign wr_dbw_lo = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_DBW_LO);
	assign wr_dbw_hi = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_DBW_HI);
	assign wr_duty_lo = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_DUTY_LO);
	assign wr_duty_hi = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_DUTY_HI);
	assign wr_dbs = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_DBS);
	assign wr_chan = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_CHAN_SEL);
	assign wr_irq = reg_we_i && (reg_addr_i == spwm_pkg::ADDR_PWM_IRQ);

	// ********************************************************
	// Counter state
	// ********************************************************
	spwm_pkg::spwm_state_t state_q;
	spwm_pkg::spwm_state_t state_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic synced_q;
	logic tick;
	logic running;
	logic at_end;
	logic ovf;
	logic period_zero;
	logic [15:0] pulse_end;
	logic raw_level;
	logic cmp_block;
	logic [5:0] sel6;

	assign period_zero = (period_q == spwm_pkg::RESET_WORD);
	assign running = (state_q == spwm_pkg::SPWM_RUN) && en_q;
	// R08 zero lock
	assign period_lock = (state_q == spwm_pkg::SPWM_HALT) || (en_q && period_zero);
	assign at_end = (cnt_q == 16'(period_q - 16'h0001));
	// R19 overflow point
	assign ovf = running && tick && at_end;

	// R03 divider
	spwm_prescaler #(
		.DIV_BITS(spwm_pkg::DIV_BITS)
	) u_prescaler (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.run_i(running),
		.code_i(mode_q[spwm_pkg::MODE_DIV_LSB +: 3]),
		.tick_o(tick)
	);

	// R07 R20 one-pulse self clear, a software write wins
	assign en_d = wr_mode ? reg_wdata_i[spwm_pkg::MODE_EN_BIT] : (en_q && !(ovf && mode_q[spwm_pkg::MODE_ONEP_BIT]));

	// R08 halt state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			spwm_pkg::SPWM_IDLE: begin
				if (en_q) begin
					state_d = period_zero ? spwm_pkg::SPWM_HALT : spwm_pkg::SPWM_RUN;
				end
			end
			spwm_pkg::SPWM_RUN, spwm_pkg::SPWM_HALT: begin
				if (!en_q) begin
					state_d = spwm_pkg::SPWM_IDLE;
				end
			end
			default: begin
				state_d = spwm_pkg::SPWM_IDLE;
			end
		endcase
	end

	// R19 restart from zero
	assign cnt_d = !running ? spwm_pkg::RESET_WORD :
		(!tick ? cnt_q : (at_end ? spwm_pkg::RESET_WORD : 16'(cnt_q + 16'h0001)));

	// R15 hardware set beats software clear
	assign flag_d = ovf ? 1'b1 : (wr_irq ? reg_wdata_i[spwm_pkg::IRQ_FLAG_BIT] : flag_q);

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_q <= spwm_pkg::SPWM_IDLE;
			cnt_q <= spwm_pkg::RESET_WORD;
			synced_q <= 1'b0;
			en_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			// R22 first counter boundary
			synced_q <= running && (synced_q || tick);
			en_q <= en_d;
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			chan_sel_q <= spwm_pkg::RESET_BYTE;
			mode_q <= 7'h00;
			period_q <= spwm_pkg::RESET_WORD;
			duty_q <= spwm_pkg::RESET_WORD;
			dbw_q <= spwm_pkg::RESET_WORD;
			dbs_q <= spwm_pkg::RESET_BYTE;
			pwm_irq_en_q <= 1'b0;
			global_en_q <= 1'b0;
		end else begin
			// R01 R02 channel select
			if (wr_chan) chan_sel_q <= reg_wdata_i & spwm_pkg::CHAN_SEL_MASK;
			if (wr_mode) mode_q <= reg_wdata_i[6:0];
			// R10 period bytes
			if (wr_per_lo) period_q[7:0] <= reg_wdata_i;
			if (wr_per_hi) period_q[15:8] <= reg_wdata_i;
			// R11 duty bytes
			if (wr_duty_lo) duty_q[7:0] <= reg_wdata_i;
			if (wr_duty_hi) duty_q[15:8] <= reg_wdata_i;
			// R12 R13 dead bands
			if (wr_dbw_lo) dbw_q[7:0] <= reg_wdata_i;
			if (wr_dbw_hi) dbw_q[15:8] <= reg_wdata_i;
			if (wr_dbs) dbs_q <= reg_wdata_i;
			if (wr_irq) pwm_irq_en_q <= reg_wdata_i[spwm_pkg::IRQ_EN_BIT];
			if (wr_global) global_en_q <= reg_wdata_i[spwm_pkg::GIRQ_EN_BIT];
		end
	end

	// ********************************************************
	// Read port, data one cycle after the strobe
	// ********************************************************
	always_comb begin
		rdata_d = spwm_pkg::RESET_BYTE;
		unique case (reg_addr_i)
			spwm_pkg::ADDR_GLOBAL_IRQ: rdata_d = {global_en_q, 7'h00};
			spwm_pkg::ADDR_MODE: rdata_d = {en_q, mode_q};
			spwm_pkg::ADDR_PERIOD_LO: rdata_d = period_q[7:0];
			spwm_pkg::ADDR_PERIOD_HI: rdata_d = period_q[15:8];
			spwm_pkg::ADDR_DBW_LO: rdata_d = dbw_q[7:0];
			spwm_pkg::ADDR_DBW_HI: rdata_d = dbw_q[15:8];
			spwm_pkg::ADDR_DUTY_LO: rdata_d = duty_q[7:0];
			spwm_pkg::ADDR_DUTY_HI: rdata_d = duty_q[15:8];
			spwm_pkg::ADDR_DBS: rdata_d = dbs_q;
			spwm_pkg::ADDR_CHAN_SEL: rdata_d = chan_sel_q;
			spwm_pkg::ADDR_PWM_IRQ: rdata_d = {pwm_irq_en_q, 3'h0, flag_q, 3'h0};
			default: rdata_d = spwm_pkg::RESET_BYTE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_q <= spwm_pkg::RESET_BYTE;
		end else begin
			rdata_q <= reg_re_i ? rdata_d : spwm_pkg::RESET_BYTE;
		end
	end
	assign reg_rdata_o = rdata_q;

	// R14 R16 R21 interrupt gating
	assign irq_o = flag_q && pwm_irq_en_q && global_en_q;

	// ********************************************************
	// Comparator trigger, three-stage synchroniser
	// ********************************************************
	logic cmp_s1_q;
	logic cmp_s2_q;
	logic cmp_s3_q;
	logic cmp_ok_q;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
			cmp_s3_q <= 1'b0;
			cmp_ok_q <= 1'b0;
		end else begin
			cmp_s1_q <= cmp_trig_i;
			cmp_s2_q <= cmp_s1_q;
			cmp_s3_q <= cmp_s2_q;
			if (cmp_s2_q == cmp_s3_q) cmp_ok_q <= cmp_s3_q;
		end
	end

	// ********************************************************
	// Waveform and channel drive
	// ********************************************************
	// Pulse ends at duty minus the wide dead band; an oversized dead band gives no pulse
	assign pulse_end = (dbw_q > duty_q) ? spwm_pkg::RESET_WORD : 16'(duty_q - dbw_q);
	// R17 R18 R13 compare window
	assign raw_level = running && (cnt_q >= {8'h00, dbs_q}) && (cnt_q < pulse_end) && (cnt_q < duty_q);
	// R06 comparator stop
	assign cmp_block = mode_q[spwm_pkg::MODE_SYNC_BIT] && !cmp_ok_q;
	assign sel6 = {chan_sel_q[6:4], chan_sel_q[2:0]};

	spwm_chan_if chan_bus ();

	// R01 R02 R22 drive after sync
	assign chan_bus.drive = (running && synced_q) ? sel6 : 6'h00;
	assign chan_bus.level = {6{raw_level && !cmp_block}};
	// R04 R05 group inversion
	assign chan_bus.inv_a = mode_q[spwm_pkg::MODE_INVA_BIT];
	assign chan_bus.inv_b = mode_q[spwm_pkg::MODE_INVB_BIT];

	spwm_pinmux u_pinmux (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.chan(chan_bus),
		.gpio_out_i(gpio_out_i),
		.gpio_oe_i(gpio_oe_i),
		.pin_out_o(pin_out_o),
		.pin_oe_o(pin_oe_o)
	);

	// ********************************************************
	// Assertions
	// ********************************************************
	property p_sel_drive;
		@(posedge clk_i) disable iff (!resetn_i)
		(running && synced_q && chan_sel_q[4] && chan_sel_q[0]) |=> (pin_oe_o[3] && pin_oe_o[0]);
	endproperty
	a_sel_drive: assert property (p_sel_drive) else $error("selected channel not driven"); // R01 R02

	property p_div1;
		@(posedge clk_i) disable iff (!resetn_i)
		(running && mode_q[6:4] == 3'b111 && $past(running)) |-> tick;
	endproperty
	a_div1: assert property (p_div1) else $error("divide by one missed a tick"); // R03

	property p_div128;
		@(posedge clk_i) disable iff (!resetn_i)
		(tick && mode_q[6:4] == 3'b000 && !wr_mode) |=> !tick [*8];
	endproperty
	a_div128: assert property (p_div128) else $error("divide by 128 ticked too soon"); // R03

	property p_inv_b;
		@(posedge clk_i) disable iff (!resetn_i)
		chan_bus.drive[3] |=> (pin_out_o[3] == ($past(chan_bus.level[3]) ^ $past(chan_bus.inv_b)));
	endproperty
	a_inv_b: assert property (p_inv_b) else $error("group B inversion wrong"); // R04

	property p_inv_a;
		@(posedge clk_i) disable iff (!resetn_i)
		chan_bus.drive[0] |=> (pin_out_o[0] == ($past(chan_bus.level[0]) ^ $past(chan_bus.inv_a)));
	endproperty
	a_inv_a: assert property (p_inv_a) else $error("group A inversion wrong"); // R05

	property p_nosync;
		@(posedge clk_i) disable iff (!resetn_i)
		!mode_q[spwm_pkg::MODE_SYNC_BIT] |-> (chan_bus.level[0] == raw_level);
	endproperty
	a_nosync: assert property (p_nosync) else $error("comparator acted while sync off"); // R06

	property p_halt_lock;
		@(posedge clk_i) disable iff (!resetn_i)
		(state_q == spwm_pkg::SPWM_HALT) |=> (period_q == $past(period_q));
	endproperty
	a_halt_lock: assert property (p_halt_lock) else $error("period changed while halted"); // R08

	property p_flag_sticky;
		@(posedge clk_i) disable iff (!resetn_i)
		(flag_q && !wr_irq) |=> flag_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("request flag lost"); // R15

	property p_restart;
		@(posedge clk_i) disable iff (!resetn_i)
		ovf |=> (cnt_q == 16'h0000) && flag_q;
	endproperty
	a_restart: assert property (p_restart) else $error("overflow did not restart"); // R17 R19

	property p_low_at_duty;
		@(posedge clk_i) disable iff (!resetn_i)
		(cnt_q >= duty_q) |-> !raw_level;
	endproperty
	a_low_at_duty: assert property (p_low_at_duty) else $error("output high past duty"); // R18

	property p_one_pulse;
		@(posedge clk_i) disable iff (!resetn_i)
		(ovf && mode_q[spwm_pkg::MODE_ONEP_BIT] && !wr_mode) |=> !en_q ##1 (chan_bus.drive == 6'h00);
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("one pulse did not stop"); // R07 R20

	property p_irq;
		@(posedge clk_i) disable iff (!resetn_i)
		irq_o |-> (pwm_irq_en_q && global_en_q && flag_q);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without enables"); // R14 R16 R21

	c_ovf: cover property (@(posedge clk_i) disable iff (!resetn_i) ovf);
	c_halt: cover property (@(posedge clk_i) disable iff (!resetn_i) state_q == spwm_pkg::SPWM_HALT);
	c_irq: cover property (@(posedge clk_i) disable iff (!resetn_i) irq_o);
	c_block: cover property (@(posedge clk_i) disable iff (!resetn_i) running && cmp_block);

endmodule
`default_nettype wire

//--- spwm_pkg.sv
`default_nettype none
package spwm_pkg;

	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [7:0] ADDR_GLOBAL_IRQ = 8'hA8;
	localparam logic [7:0] ADDR_MODE = 8'hAB;
	localparam logic [7:0] ADDR_PERIOD_LO = 8'hAC;
	localparam logic [7:0] ADDR_PERIOD_HI = 8'hAD;
	localparam logic [7:0] ADDR_DBW_LO = 8'hAE;
	localparam logic [7:0] ADDR_DBW_HI = 8'hAF;
	localparam logic [7:0] ADDR_DUTY_LO = 8'hBB;
	localparam logic [7:0] ADDR_DUTY_HI = 8'hBC;
	localparam logic [7:0] ADDR_DBS = 8'hBD;
	localparam logic [7:0] ADDR_CHAN_SEL = 8'hBE;
	localparam logic [7:0] ADDR_PWM_IRQ = 8'hD1;

	// ********************************************************
	// Field positions and reset values
	// ********************************************************
	localparam int MODE_EN_BIT = 7;
	localparam int MODE_DIV_LSB = 4;
	localparam int MODE_INVB_BIT = 3;
	localparam int MODE_INVA_BIT = 2;
	localparam int MODE_SYNC_BIT = 1;
	localparam int MODE_ONEP_BIT = 0;
	localparam int IRQ_EN_BIT = 7;
	localparam int IRQ_FLAG_BIT = 3;
	localparam int GIRQ_EN_BIT = 7;
	localparam logic [7:0] CHAN_SEL_MASK = 8'h77;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// ********************************************************
	// Timing: largest divisor is 2**DIV_BITS
	// ********************************************************
	localparam int DIV_BITS = 7;
	localparam logic [DIV_BITS-1:0] DIV_FULL_MASK = 7'h7F;

	typedef enum logic [2:0] {
		SPWM_IDLE = 3'b001,
		SPWM_RUN = 3'b010,
		SPWM_HALT = 3'b100
	} spwm_state_t;

endpackage
`default_nettype wire

//--- spwm_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spwm_chan_if;
	logic [5:0] drive;
	logic [5:0] level;
	logic inv_a;
	logic inv_b;
	modport ctrl (output drive, output level, output inv_a, output inv_b);
	modport pins (input drive, input level, input inv_a, input inv_b);
endinterface
`default_nettype wire

//--- spwm_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module spwm_prescaler #(
	parameter int DIV_BITS = spwm_pkg::DIV_BITS
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic run_i,
	input wire logic [2:0] code_i,
	output logic tick_o
);
	// Code 0 divides by 128, each higher code halves the divisor
	logic [DIV_BITS-1:0] cnt_q;
	logic [DIV_BITS-1:0] cnt_d;
	logic [DIV_BITS-1:0] mask;

	assign mask = spwm_pkg::DIV_FULL_MASK >> code_i;
	assign tick_o = run_i && ((cnt_q & mask) == mask);
	assign cnt_d = run_i ? DIV_BITS'(cnt_q + 1'b1) : '0;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule
`default_nettype wire

//--- spwm_pinmux.sv
`timescale 1ns/1ps
`default_nettype none
module spwm_pinmux (
	input wire logic clk_i,
	input wire logic resetn_i,
	spwm_chan_if.pins chan,
	input wire logic [5:0] gpio_out_i,
	input wire logic [5:0] gpio_oe_i,
	output logic [5:0] pin_out_o,
	output logic [5:0] pin_oe_o
);
	logic [5:0] inv_mask;
	logic [5:0] out_d;
	logic [5:0] oe_d;

	// Group A is channels 2..0, group B is channels 5..3
	assign inv_mask = {{3{chan.inv_b}}, {3{chan.inv_a}}};
	// Released channels fall straight back to the GPIO values
	assign out_d = (chan.drive & (chan.level ^ inv_mask)) | (~chan.drive & gpio_out_i);
	assign oe_d = chan.drive | gpio_oe_i;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pin_out_o <= '0;
			pin_oe_o <= '0;
		end else begin
			pin_out_o <= out_d;
			pin_oe_o <= oe_d;
		end
	end
endmodule
`default_nettype wire

//--- spwm_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module spwm_pin_partner #(
	parameter logic [5:0] GPIO_LEVEL = 6'h15,
	parameter logic [5:0] GPIO_DRIVE = 6'h2A
) (
	input wire logic run_allowed_i,
	output logic [5:0] gpio_out_o,
	output logic [5:0] gpio_oe_o,
	output var logic cmp_trig_o
);
	// ********************************************************
	// Port logic and comparator
	// ********************************************************
	// Fixed levels, so a pin handed back to port logic can be compared directly
	assign gpio_out_o = GPIO_LEVEL;
	assign gpio_oe_o = GPIO_DRIVE;

	// Comparator is asynchronous: it settles away from the clock edge
	initial cmp_trig_o = 1'b1;
	always @(run_allowed_i) begin
		cmp_trig_o <= #3 run_allowed_i;
	end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i;
	logic resetn_i;
	logic [7:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic reg_we_i;
	logic reg_re_i;
	logic [7:0] reg_rdata_o;
	logic cmp_trig_i;
	logic cmp_run;
	logic [5:0] gpio_out_i;
	logic [5:0] gpio_oe_i;
	logic [5:0] pin_out_o;
	logic [5:0] pin_oe_o;
	logic irq_o;
	int failures;
	int tests_run;
	int cycles = 0;
	int hi [6];
	int div;
	logic [7:0] addrs [11] = '{spwm_pkg::ADDR_GLOBAL_IRQ, spwm_pkg::ADDR_MODE, spwm_pkg::ADDR_PERIOD_LO,
		spwm_pkg::ADDR_PERIOD_HI, spwm_pkg::ADDR_DBW_LO, spwm_pkg::ADDR_DBW_HI, spwm_pkg::ADDR_DUTY_LO,
		spwm_pkg::ADDR_DUTY_HI, spwm_pkg::ADDR_DBS, spwm_pkg::ADDR_CHAN_SEL, spwm_pkg::ADDR_PWM_IRQ};

	spwm_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .cmp_trig_i(cmp_trig_i),
		.gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
		.irq_o(irq_o));

	spwm_pin_partner partner (.run_allowed_i(cmp_run), .gpio_out_o(gpio_out_i), .gpio_oe_o(gpio_oe_i),
		.cmp_trig_o(cmp_trig_i));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ********************************************************
	// Bus tasks and checks
	// ********************************************************
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1;
		check(name, {8'h00, exp}, {8'h00, reg_rdata_o});
	endtask

	// Counting over whole periods makes the result independent of phase
	task automatic measure(input int n);
		for (int i = 0; i < 6; i++) hi[i] = 0;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			for (int i = 0; i < 6; i++) hi[i] += (pin_out_o[i] === 1'b1);
		end
	endtask

	task automatic conclude();
		$display("Checks run %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		failures = 0;
		tests_run = 0;
		cmp_run = 1'b1;
		resetn_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		foreach (addrs[i]) rd(addrs[i], 8'h00, "reset value");
		rd(8'hA0, 8'h00, "unmapped read");
		wr(spwm_pkg::ADDR_CHAN_SEL, 8'hFF);
		rd(spwm_pkg::ADDR_CHAN_SEL, 8'h77, "channel select");
		wr(spwm_pkg::ADDR_DUTY_HI, 8'hA5);
		rd(spwm_pkg::ADDR_DUTY_HI, 8'hA5, "duty high");
		wr(spwm_pkg::ADDR_DUTY_HI, 8'h00);
		// Period low byte written before any enable, high byte left at reset
		wr(spwm_pkg::ADDR_PERIOD_LO, 8'h04);
		wr(spwm_pkg::ADDR_DUTY_LO, 8'h01);
		wr(spwm_pkg::ADDR_CHAN_SEL, 8'h05);
		wr(spwm_pkg::ADDR_MODE, 8'hF0);
		repeat (30) @(posedge clk_i);
		#1;
		check("unselected out", {12'h000, gpio_out_i[5:3], gpio_out_i[1]}, {12'h000, pin_out_o[5:3], pin_out_o[1]});
		check("unselected oe", {12'h000, gpio_oe_i[5:3], gpio_oe_i[1]}, {12'h000, pin_oe_o[5:3], pin_oe_o[1]});
		check("selected oe", 16'h0003, {14'h0000, pin_oe_o[2], pin_oe_o[0]});

		wr(spwm_pkg::ADDR_CHAN_SEL, 8'h77);
		for (int c = 0; c < 8; c++) begin
			div = 128 >> c;
			wr(spwm_pkg::ADDR_MODE, 8'h00);
			wr(spwm_pkg::ADDR_MODE, 8'h80 | 8'(c << 4) | ((c % 2) ? 8'h04 : 8'h08));
			repeat (12 * div + 10) @(posedge clk_i);
			measure(8 * div);
			check("group a high", 16'((c % 2) ? 6 * div : 2 * div), 16'(hi[0]));
			check("group b high", 16'((c % 2) ? 2 * div : 6 * div), 16'(hi[5]));
			check("pin enables", 16'h003F, {10'h000, pin_oe_o});
		end

		// Dead bands: period 8, duty 6, trimmed 2 at the end, 1 at the start
		wr(spwm_pkg::ADDR_MODE, 8'h00);
		wr(spwm_pkg::ADDR_PERIOD_LO, 8'h08);
		wr(spwm_pkg::ADDR_DUTY_LO, 8'h06);
		wr(spwm_pkg::ADDR_DBW_LO, 8'h02);
		wr(spwm_pkg::ADDR_DBS, 8'h01);
		wr(spwm_pkg::ADDR_MODE, 8'hF0);
		repeat (30) @(posedge clk_i);
		measure(16);
		check("dead band high", 16'd6, 16'(hi[2]));
		cmp_run <= 1'b0;
		repeat (10) @(posedge clk_i);
		measure(16);
		check("no sync high", 16'd6, 16'(hi[2]));
		wr(spwm_pkg::ADDR_MODE, 8'hF2);
		repeat (10) @(posedge clk_i);
		measure(16);
		check("comparator stop", 16'd0, 16'(hi[2]));
		cmp_run <= 1'b1;
		repeat (30) @(posedge clk_i);
		measure(16);
		check("comparator run", 16'd6, 16'(hi[2]));

		// Flag and request gating
		wr(spwm_pkg::ADDR_MODE, 8'h00);
		repeat (4) @(posedge clk_i);
		rd(spwm_pkg::ADDR_PWM_IRQ, 8'h08, "sticky flag");
		wr(spwm_pkg::ADDR_PWM_IRQ, 8'h88);
		#1;
		check("irq global off", 16'h0000, {15'h0000, irq_o});
		wr(spwm_pkg::ADDR_GLOBAL_IRQ, 8'h80);
		#1;
		check("irq all on", 16'h0001, {15'h0000, irq_o});
		wr(spwm_pkg::ADDR_PWM_IRQ, 8'h08);
		#1;
		check("irq local off", 16'h0000, {15'h0000, irq_o});
		wr(spwm_pkg::ADDR_PWM_IRQ, 8'h80);
		#1;
		check("irq cleared", 16'h0000, {15'h0000, irq_o});
		rd(spwm_pkg::ADDR_PWM_IRQ, 8'h80, "flag cleared");

		// One pulse then self disable
		wr(spwm_pkg::ADDR_MODE, 8'hF1);
		repeat (30) @(posedge clk_i);
		rd(spwm_pkg::ADDR_MODE, 8'h71, "one pulse enable");
		rd(spwm_pkg::ADDR_PWM_IRQ, 8'h88, "one pulse flag");
		check("one pulse oe", {10'h000, gpio_oe_i}, {10'h000, pin_oe_o});
		check("one pulse out", {10'h000, gpio_out_i}, {10'h000, pin_out_o});

		// Zero period with enable locks the period
		wr(spwm_pkg::ADDR_PERIOD_LO, 8'h00);
		wr(spwm_pkg::ADDR_MODE, 8'hF0);
		wr(spwm_pkg::ADDR_PERIOD_LO, 8'h05);
		rd(spwm_pkg::ADDR_PERIOD_LO, 8'h00, "locked period");
		wr(spwm_pkg::ADDR_MODE, 8'h00);
		wr(spwm_pkg::ADDR_PERIOD_LO, 8'h05);
		rd(spwm_pkg::ADDR_PERIOD_LO, 8'h05, "period after halt");
		conclude();
	end
endmodule
`default_nettype wire
